// ### verilog/ebm_ctrl.sv
// ebm_ctrl.sv: external bus mode controller; boot latch, bus mode,
// pin sharing between port bits and the external bus.
// assumes: core gives one access per cycle on acc_*, same clock;
// the boot pin is asynchronous and is synchronised here.
//
// Summary of operation
// - boot pin high selects internal rom, external memory still allowed.
// - boot pin low releases the rom area to external memory.
// - boot pin level caught when reset releases; new level needs reset.
// - internal accesses in rom mode drive no strobes; data lines float.
// - external boot: rom range goes external, other internal stays quiet.
// - rom mode: internal rom holds vectors at start of program memory.
// - rom mode starts single chip; external after software sets mode.
// - external boot starts from external memory, mode from option.
// - four bus modes selectable by software.
// - single chip mode refused while in external boot.
// - single chip: all bus pins but the chip enables are general ports; chip enables held high.
// - single chip: only internal addresses under 64k are valid.
// - expanded 64k only in external boot, window to 00efff.
// - top 4k of first 64k always internal in expanded modes.
// - expanded 64k offers four chip-enable range sizes.
// - 512k modes work in both boots, map high or from zero.
// - 512k minimum runs core in minimum addressing.
// - 512k maximum runs core in maximum addressing.
// - 512k modes: each chip enable covers a fixed 512k.
// - data lines are port pins in single chip, data bus otherwise.
// - detached port data and direction stay general storage.
// - address pins: ports, low 16 in 64k, all 19 in 512k modes.
// - detached address port registers stay general storage.
// - strobes share two port bits and fire only externally.
`include "ebm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module ebm_ctrl
  import ebm_pkg::*;
#(
  parameter logic [1:0] MPU_BOOT_MODE = `EBM_DEF_MPU_MODE
)(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  input  wire logic                   boot_source_select_pin,
  // software mode writes
  input  wire logic                   mode_wr,
  input  wire logic [1:0]             mode_wdata,
  input  wire logic [1:0]             ce_size_wdata,
  output logic [1:0]                  bus_mode,
  output logic [1:0]                  ce_size,
  output logic                        boot_rom_mode,
  output logic                        core_max_mode,
  // core access
  input  wire logic                   acc_req,
  input  wire logic                   acc_wr,
  input  wire logic [`EBM_PHYS_W-1:0] acc_addr,
  input  wire logic [7:0]             acc_wdata,
  output logic                        acc_ext,
  output logic                        acc_invalid,
  output logic [7:0]                  acc_rdata,
  // port registers written by software
  input  wire logic [7:0]             shared_bidir_port_bits,
  input  wire logic [7:0]             bidir_dir,
  input  wire logic [7:0]             low_address_port_bits,
  input  wire logic [7:0]             mid_address_port_bits,
  input  wire logic [2:0]             upper_address_port_bits,
  input  wire logic                   read_strobe_port_bit,
  input  wire logic                   write_strobe_port_bit,
  input  wire logic [20:0]            out_port_hiz,
  output logic [7:0]                  bidir_port_in,
  // pins
  input  wire logic [7:0]             external_data_lines_i,
  output logic [7:0]                  external_data_lines_o,
  output logic [7:0]                  external_data_lines_oe,
  output logic [18:0]                 external_address_lines,
  output logic [18:0]                 external_address_lines_oe,
  output logic                        read_strobe_b,
  output logic                        read_strobe_oe,
  output logic                        write_strobe_b,
  output logic                        write_strobe_oe,
  output logic [3:0]                  chip_enable_b
);
  ebm_dec_if dif ();

  logic                boot_s1_q;
  logic                boot_s2_q;
  logic                boot_rom_q;
  logic                armed_q;
  ebm_bus_mode_t       mode_q;
  ebm_ce_size_t        ce_size_q;
  logic [7:0]          din_s1_q;
  logic [7:0]          din_s2_q;
  logic                ext_q;
  logic                wr_q;
  logic [18:0]         addr_q;
  logic [7:0]          wdata_q;
  logic [3:0]          ce_q;
  logic [7:0]          rdata_q;
  logic                rd_p1_q;
  logic                rd_p2_q;
  logic                inval_q;
  logic                bus_on;
  logic                addr_hi_on;
  ebm_bus_mode_t       mode_req;

  ebm_addr_dec u_dec (
    .d (dif.dec)
  );

  assign dif.boot_rom = boot_rom_q;
  assign dif.mode     = mode_q;
  assign dif.ce_size  = ce_size_q;
  assign dif.addr     = acc_addr;

  // boot pin synchroniser; runs through reset so that it already holds
  // the pin level when reset lifts; reset must span two clock edges
  always_ff @(posedge ref_clk) begin
    boot_s1_q <= boot_source_select_pin;
    boot_s2_q <= boot_s1_q;
  end

  // boot level caught once after reset release; frozen until next reset
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q    <= 1'b1;
      boot_rom_q <= 1'b1;
    end else if (armed_q) begin
      armed_q    <= 1'b0;
      boot_rom_q <= boot_s2_q;
    end
  end

  // requested mode as written; illegal combinations are held off at the mode write
  always_comb begin
    mode_req = ebm_bus_mode_t'(mode_wdata);
  end

  // bus mode: rom boot starts single chip, external boot from option
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q    <= ebm_bus_mode_t'(`EBM_BUS_MODE_RST);
      ce_size_q <= EBM_CE_8K;
    end else if (armed_q) begin
      mode_q <= boot_s2_q ? ebm_bus_mode_t'(`EBM_BUS_MODE_RST)
                          : ebm_bus_mode_t'(MPU_BOOT_MODE);
    end else if (mode_wr) begin
      ce_size_q <= ebm_ce_size_t'(ce_size_wdata);
      // single chip needs rom boot, 64k needs external boot
      if (!(mode_req == EBM_SINGLE && !boot_rom_q) &&
          !(mode_req == EBM_EXP64 && boot_rom_q))
        mode_q <= mode_req;
    end
  end

  // sampled data pins for reads and port input
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= external_data_lines_i;
      din_s2_q <= din_s1_q;
    end
  end

  // access stage: decode decides before any strobe or driver turns on
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_q   <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= 19'h00000;
      wdata_q <= 8'h00;
      ce_q    <= 4'h0;
      inval_q <= 1'b0;
    end else begin
      ext_q   <= acc_req && dif.is_ext;
      wr_q    <= acc_wr;
      inval_q <= acc_req && !dif.is_valid;
      ce_q    <= acc_req ? dif.ce_sel : 4'h0;
      if (acc_req) begin
        addr_q  <= acc_addr[18:0];
        wdata_q <= acc_wdata;
      end
    end
  end

  // read pending: pins seen at the end of the strobe cycle need two
  // more edges through the synchroniser before they can be taken
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_p1_q <= 1'b0;
      rd_p2_q <= 1'b0;
    end else begin
      rd_p1_q <= ext_q && !wr_q;
      rd_p2_q <= rd_p1_q;
    end
  end

  // read data: costs two cycles of latency, but never takes stale pins
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      rdata_q <= 8'h00;
    else if (rd_p2_q)
      rdata_q <= din_s2_q;
  end

  // pin function by mode
  assign bus_on     = (mode_q != EBM_SINGLE);
  assign addr_hi_on = (mode_q == EBM_EXP512MN) ||
                      (mode_q == EBM_EXP512MX);

  // port registers stay outside; detached bits keep their storage
  always_comb begin
    if (bus_on) begin
      external_data_lines_o  = wdata_q;
      external_data_lines_oe = {8{ext_q && wr_q}}; // float otherwise
    end else begin
      external_data_lines_o  = shared_bidir_port_bits;
      external_data_lines_oe = bidir_dir;
    end
    external_address_lines[15:0]    = bus_on ? addr_q[15:0] :
        {mid_address_port_bits, low_address_port_bits};
    external_address_lines_oe[15:0] = bus_on ? 16'hffff : ~out_port_hiz[15:0];
    external_address_lines[18:16]    = addr_hi_on ? addr_q[18:16] :
                                       upper_address_port_bits;
    external_address_lines_oe[18:16] = addr_hi_on ? 3'h7 :
                                       ~out_port_hiz[18:16];
  end

  // strobes only for external cycles; active low
  always_comb begin
    if (bus_on) begin
      read_strobe_b   = !(ext_q && !wr_q);
      write_strobe_b  = !(ext_q && wr_q);
      read_strobe_oe  = 1'b1;
      write_strobe_oe = 1'b1;
    end else begin
      read_strobe_b   = read_strobe_port_bit;
      write_strobe_b  = write_strobe_port_bit;
      read_strobe_oe  = !out_port_hiz[19];
      write_strobe_oe = !out_port_hiz[20];
    end
    chip_enable_b = bus_on ? ~(ce_q & {4{ext_q}}) : 4'hf;
  end

  // rom boot keeps vectors in internal rom; flag for the core map
  assign boot_rom_mode = boot_rom_q;
  assign core_max_mode = (mode_q == EBM_EXP512MX);
  assign bus_mode      = mode_q;
  assign ce_size       = ce_size_q;
  assign bidir_port_in = din_s2_q;
  assign acc_ext       = ext_q;
  assign acc_invalid   = inval_q;
  assign acc_rdata     = rdata_q;
endmodule : ebm_ctrl
`default_nettype wire

// ### verilog/ebm_regs.svh
// ebm_regs.svh: address map, field positions and reset values for the
// external bus mode controller.
// assumes: included by its bare name; plain definitions only.
`ifndef EBM_REGS_SVH
`define EBM_REGS_SVH
`define EBM_PHYS_W        24
`define EBM_ROM_LO        24'h000000
`define EBM_ROM_HI        24'h00bfff
`define EBM_COMMON_HI     24'h007fff
`define EBM_INT_TOP_LO    24'h00f000
`define EBM_INT_TOP_HI    24'h00ffff
`define EBM_WIN64_HI      24'h00efff
`define EBM_PAGE0_HI      24'h00ffff
`define EBM_MCU_EXT_LO    24'h080000
`define EBM_MCU_EXT_HI    24'h27ffff
`define EBM_MPU_EXT_HI    24'h1fffff
`define EBM_CE_FIXED_SH   19
`define EBM_BUS_MODE_RST  2'h0
`define EBM_DEF_MPU_MODE  2'h1
`endif

// ### verilog/ebm_pkg.sv
// ebm_pkg.sv: types shared by the bus mode controller and its decoder.
// assumes: nothing beyond the compile order.
`default_nettype none
package ebm_pkg;
  typedef enum logic [1:0] {
    EBM_SINGLE   = 2'h0,
    EBM_EXP64    = 2'h1,
    EBM_EXP512MN = 2'h2,
    EBM_EXP512MX = 2'h3
  } ebm_bus_mode_t;
  typedef enum logic [1:0] {
    EBM_CE_8K  = 2'h0,
    EBM_CE_16K = 2'h1,
    EBM_CE_32K = 2'h2,
    EBM_CE_64K = 2'h3
  } ebm_ce_size_t;
endpackage : ebm_pkg
`default_nettype wire

// ### verilog/ebm_dec_if.sv
// ebm_dec_if.sv: carrier between the controller and its address decoder.
// assumes: both ends sit on the same clock.
`include "ebm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
interface ebm_dec_if;
  import ebm_pkg::*;
  logic                     boot_rom;
  ebm_bus_mode_t            mode;
  ebm_ce_size_t             ce_size;
  logic [`EBM_PHYS_W-1:0]   addr;
  logic                     is_ext;
  logic                     is_valid;
  logic [3:0]               ce_sel;
  modport ctl (output boot_rom, mode, ce_size, addr,
               input  is_ext, is_valid, ce_sel);
  modport dec (input  boot_rom, mode, ce_size, addr,
               output is_ext, is_valid, ce_sel);
endinterface : ebm_dec_if
`default_nettype wire

// ### verilog/ebm_addr_dec.sv
// ebm_addr_dec.sv: combinational internal/external address classifier
// with chip-enable range selection.
// assumes: mode and boot selection are already stable flip-flop values.
`include "ebm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module ebm_addr_dec
  import ebm_pkg::*;
(
  ebm_dec_if.dec d
);
  logic [23:0] a;
  logic        in_rom;
  logic        in_top;
  assign a      = d.addr;
  assign in_rom = (a <= `EBM_ROM_HI);
  assign in_top = (a >= `EBM_INT_TOP_LO) && (a <= `EBM_INT_TOP_HI);

  // external only where the window allows; top 4k never leaves the chip
  always_comb begin
    d.is_ext   = 1'b0;
    d.is_valid = 1'b0;
    d.ce_sel   = 4'h0;
    unique case (d.mode)
      EBM_SINGLE: begin
        d.is_valid = (a <= `EBM_PAGE0_HI) && (in_rom || in_top);
      end
      EBM_EXP64: begin
        d.is_valid = (a <= `EBM_PAGE0_HI);
        d.is_ext   = !d.boot_rom && (a <= `EBM_WIN64_HI);
        if (d.is_ext) begin
          unique case (d.ce_size)
            EBM_CE_8K:  d.ce_sel = (a[15:13] < 3'h4) ?
                                   (4'h1 << a[14:13]) : 4'h0;
            EBM_CE_16K: d.ce_sel = 4'h1 << a[15:14];
            EBM_CE_32K: d.ce_sel = 4'h1 << a[15];
            EBM_CE_64K: d.ce_sel = 4'h1;
          endcase
        end
      end
      EBM_EXP512MN, EBM_EXP512MX: begin
        if (d.boot_rom) begin
          d.is_ext = (a >= `EBM_MCU_EXT_LO) && (a <= `EBM_MCU_EXT_HI);
          d.is_valid = d.is_ext || in_rom || in_top;
          // ce0 sits at the top in this map, rest in 512k steps
          if (d.is_ext)
            d.ce_sel = (a[21:19] == 3'h4) ? 4'h1 : (4'h1 << a[20:19]);
        end else begin
          d.is_ext   = (a <= `EBM_MPU_EXT_HI) && !in_top;
          d.is_valid = d.is_ext || in_top;
          if (d.is_ext)
            d.ce_sel = 4'h1 << a[20:19];
        end
      end
    endcase
  end
endmodule : ebm_addr_dec
`default_nettype wire

// ### dv/ebm_props.sv
// ebm_props.sv: port checker for the bus mode controller.
// assumes: bound onto ebm_ctrl; one clock, async active-low reset.
`timescale 1ns/10ps
`default_nettype none
module ebm_props (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        mode_wr,
  input wire logic [1:0]  bus_mode,
  input wire logic        boot_rom_mode,
  input wire logic        core_max_mode,
  input wire logic        acc_req,
  input wire logic        acc_wr,
  input wire logic [23:0] acc_addr,
  input wire logic [7:0]  acc_wdata,
  input wire logic        acc_ext,
  input wire logic        acc_invalid,
  input wire logic [7:0]  bidir_dir,
  input wire logic [2:0]  upper_address_port_bits,
  input wire logic [20:0] out_port_hiz,
  input wire logic [7:0]  external_data_lines_o,
  input wire logic [7:0]  external_data_lines_oe,
  input wire logic [18:0] external_address_lines,
  input wire logic [18:0] external_address_lines_oe,
  input wire logic        read_strobe_b,
  input wire logic        write_strobe_b,
  input wire logic [3:0]  chip_enable_b
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic rom_a, top_a, go;
  // mode must hold over the access, so skip cycles with a mode write
  assign rom_a = acc_addr <= 24'h00bfff;
  assign top_a = acc_addr >= 24'h00f000 && acc_addr <= 24'h00ffff;
  assign go    = acc_req && !mode_wr && bus_mode != 2'h0;
  a_mcu_rom_quiet: assert property (go && boot_rom_mode && rom_a |=>
    read_strobe_b && write_strobe_b && chip_enable_b == 4'hf)
    else $error("strobe on internal rom access");
  a_mpu_rom_ext: assert property (go && !boot_rom_mode && rom_a |=> acc_ext)
    else $error("released rom range not external");
  a_top_internal: assert property (go && top_a |=>
    !acc_ext && chip_enable_b == 4'hf) else $error("top 4k went external");
  a_no_single_mpu: assert property (!boot_rom_mode |-> bus_mode != 2'h0)
    else $error("single chip in external boot");
  a_no_exp64_mcu: assert property (boot_rom_mode |-> bus_mode != 2'h1)
    else $error("expanded 64k in rom boot");
  a_single_ports: assert property (bus_mode == 2'h0 |->
    external_data_lines_oe == bidir_dir &&
    external_address_lines_oe == ~out_port_hiz[18:0])
    else $error("single chip pins not ports");
  a_exp64_pins: assert property (bus_mode == 2'h1 |->
    external_address_lines_oe[15:0] == 16'hffff &&
    external_address_lines[18:16] == upper_address_port_bits &&
    external_address_lines_oe[18:16] == ~out_port_hiz[18:16])
    else $error("64k address pin split wrong");
  a_wide_addr: assert property (bus_mode[1] |-> &external_address_lines_oe)
    else $error("512k address pins not all bus");
  a_core_max: assert property (core_max_mode == (bus_mode == 2'h3))
    else $error("core addressing mode mismatch");
  a_rd_ext_only: assert property (go && !acc_wr |=>
    read_strobe_b == !acc_ext && write_strobe_b)
    else $error("read strobe not tied to external");
  a_wr_drive: assert property (go && acc_wr |=> write_strobe_b == !acc_ext &&
    (write_strobe_b || external_data_lines_oe == 8'hff &&
    external_data_lines_o == $past(acc_wdata)))
    else $error("write cycle pins wrong");
  a_single_valid: assert property (acc_req && !mode_wr && bus_mode == 2'h0 &&
    acc_addr[23:16] != 8'h00 |=> acc_invalid)
    else $error("single chip access above 64k valid");
  a_ce_fixed: assert property (go && bus_mode[1] && acc_addr[23:19] == 5'h02 |=>
    chip_enable_b == 4'hb) else $error("fixed 512k enable wrong");
  a_ext_pulse: assert property (acc_ext |-> $past(acc_req))
    else $error("external flag without request");
endmodule : ebm_props
bind ebm_ctrl ebm_props u_props (.ref_clk(ref_clk), .rst_b(rst_b),
  .mode_wr(mode_wr), .bus_mode(bus_mode), .boot_rom_mode(boot_rom_mode),
  .core_max_mode(core_max_mode), .acc_req(acc_req), .acc_wr(acc_wr),
  .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_ext(acc_ext),
  .acc_invalid(acc_invalid), .bidir_dir(bidir_dir),
  .upper_address_port_bits(upper_address_port_bits),
  .out_port_hiz(out_port_hiz), .external_data_lines_o(external_data_lines_o),
  .external_data_lines_oe(external_data_lines_oe),
  .external_address_lines(external_address_lines),
  .external_address_lines_oe(external_address_lines_oe),
  .read_strobe_b(read_strobe_b), .write_strobe_b(write_strobe_b),
  .chip_enable_b(chip_enable_b));
`default_nettype wire

// ### dv/ebm_ext_mem.sv
// ebm_ext_mem.sv: one-cell external memory on the shared data bus.
// assumes: same clock as the controller; strobes and enables low active.
`timescale 1ns/10ps
`default_nettype none
module ebm_ext_mem (
  input  wire logic       ref_clk,
  input  wire logic [3:0] chip_enable_b,
  input  wire logic       read_strobe_b,
  input  wire logic       write_strobe_b,
  input  wire logic [7:0] data_o,
  input  wire logic [7:0] data_oe,
  output logic      [7:0] data_i
);
  logic [7:0] cell_q = 8'h3c;
  // byte taken only on a selected write with the bus fully driven
  always_ff @(posedge ref_clk) begin
    if (!write_strobe_b && chip_enable_b != 4'hf && data_oe == 8'hff) begin
      cell_q <= data_o;
    end
  end
  // drives only on a selected read; otherwise the pull-up level shows
  assign data_i = (!read_strobe_b && chip_enable_b != 4'hf) ?
                  cell_q : 8'hff;
endmodule : ebm_ext_mem
`default_nettype wire

// ### dv/tb_top.sv
// tb_top.sv: directed bench for the bus mode controller.
// assumes: ebm_props bound by its own file; 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
  import ebm_pkg::*;
  logic        ref_clk = 1'b0, rst_b = 1'b0, boot_pin = 1'b1;
  logic        mode_wr = 1'b0, acc_req = 1'b0, acc_wr = 1'b0;
  logic [1:0]  mode_wdata = 2'h0, ce_wdata = 2'h0, bus_mode, ce_size;
  logic [23:0] acc_addr = 24'h000000;
  logic [7:0]  acc_wdata = 8'h00, bidir_dir = 8'h0f;
  logic [7:0]  d_i, d_o, d_oe, acc_rdata, port_in;
  logic [2:0]  upper = 3'h2;
  logic [20:0] hiz = 21'h0000f0;
  logic        boot_rom, core_max, acc_ext, acc_inv, rd_b, rd_oe, wr_b, wr_oe;
  logic [18:0] a_out, a_oe;
  logic [3:0]  ce_b;
  logic [3:0]  ce_tab [4] = '{4'h7, 4'hd, 4'he, 4'he};
  int          n_fail = 0, num_checks = 0;
  // free-running clock, 20 ns period
  always #10 ref_clk = ~ref_clk;
  ebm_ctrl DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .boot_source_select_pin(boot_pin), .mode_wr(mode_wr),
    .mode_wdata(mode_wdata), .ce_size_wdata(ce_wdata), .bus_mode(bus_mode),
    .ce_size(ce_size), .boot_rom_mode(boot_rom), .core_max_mode(core_max),
    .acc_req(acc_req), .acc_wr(acc_wr), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_ext(acc_ext), .acc_invalid(acc_inv),
    .acc_rdata(acc_rdata), .shared_bidir_port_bits(8'h5a),
    .bidir_dir(bidir_dir), .low_address_port_bits(8'h33),
    .mid_address_port_bits(8'hcc), .upper_address_port_bits(upper),
    .read_strobe_port_bit(1'b1), .write_strobe_port_bit(1'b1),
    .out_port_hiz(hiz), .bidir_port_in(port_in),
    .external_data_lines_i(d_i), .external_data_lines_o(d_o),
    .external_data_lines_oe(d_oe), .external_address_lines(a_out),
    .external_address_lines_oe(a_oe), .read_strobe_b(rd_b),
    .read_strobe_oe(rd_oe), .write_strobe_b(wr_b), .write_strobe_oe(wr_oe),
    .chip_enable_b(ce_b));
  ebm_ext_mem u_mem (.ref_clk(ref_clk), .chip_enable_b(ce_b),
    .read_strobe_b(rd_b),
    .write_strobe_b(wr_b), .data_o(d_o), .data_oe(d_oe), .data_i(d_i));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // boot pin set before release; requests wait past the latch edge
  task automatic do_reset(input logic pin);
    boot_pin <= pin;
    rst_b    <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask : do_reset
  task automatic set_mode(input logic [1:0] m, input logic [1:0] c);
    mode_wr    <= 1'b1;
    mode_wdata <= m;
    ce_wdata   <= c;
    @(posedge ref_clk);
    mode_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : set_mode
  // one request pulse; flags and enables stand only in the next cycle
  task automatic access(input logic w, input logic [23:0] a,
                        input logic [7:0] wd, input logic ex,
                        input logic iv, input logic [3:0] ce);
    acc_req   <= 1'b1;
    acc_wr    <= w;
    acc_addr  <= a;
    acc_wdata <= wd;
    @(posedge ref_clk);
    acc_req <= 1'b0;
    #1;
    `CHK("acc_ext", ex, acc_ext)
    `CHK("acc_invalid", iv, acc_inv)
    `CHK("chip_enable_b", ce, ce_b)
    @(posedge ref_clk);
    #1;
  endtask : access
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test;
  end
  initial begin
    do_reset(1'b1);
    `CHK("boot_rom_mode", 1'b1, boot_rom)
    `CHK("bus_mode", 2'h0, bus_mode)
    `CHK("data_oe", 8'h0f, d_oe)
    `CHK("addr_oe", 19'h7ff0f, a_oe)
    `CHK("addr", 19'h2cc33, a_out)
    `CHK("data_o", 8'h5a, d_o)
    `CHK("port_in", 8'hff, port_in)
    `CHK("rd_oe", 1'b1, rd_oe)
    bidir_dir <= 8'hf0;
    hiz       <= 21'h10000f;
    @(posedge ref_clk);
    #1;
    `CHK("data_oe", 8'hf0, d_oe)
    `CHK("addr_oe", 19'h7fff0, a_oe)
    `CHK("wr_oe", 1'b0, wr_oe)
    access(1'b0, 24'h000100, 8'h00, 1'b0, 1'b0, 4'hf);
    access(1'b0, 24'h010000, 8'h00, 1'b0, 1'b1, 4'hf);
    set_mode(2'h1, 2'h0);
    `CHK("bus_mode", 2'h0, bus_mode)
    set_mode(2'h3, 2'h0);
    `CHK("bus_mode", 2'h3, bus_mode)
    `CHK("core_max_mode", 1'b1, core_max)
    `CHK("wr_oe", 1'b1, wr_oe)
    access(1'b1, 24'h180000, 8'ha5, 1'b1, 1'b0, 4'h7);
    repeat (3) @(posedge ref_clk);
    access(1'b0, 24'h180010, 8'h00, 1'b1, 1'b0, 4'h7);
    `CHK("addr", 19'h00010, a_out)
    // read data lands two edges later, behind the pin synchroniser
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("acc_rdata", 8'ha5, acc_rdata)
    access(1'b0, 24'h100000, 8'h00, 1'b1, 1'b0, 4'hb);
    access(1'b0, 24'h080000, 8'h00, 1'b1, 1'b0, 4'hd);
    access(1'b0, 24'h000100, 8'h00, 1'b0, 1'b0, 4'hf);
    access(1'b0, 24'h00f000, 8'h00, 1'b0, 1'b0, 4'hf);
    set_mode(2'h2, 2'h0);
    `CHK("core_max_mode", 1'b0, core_max)
    boot_pin <= 1'b0;
    repeat (5) @(posedge ref_clk);
    `CHK("boot_rom_mode", 1'b1, boot_rom)
    do_reset(1'b0);
    `CHK("boot_rom_mode", 1'b0, boot_rom)
    `CHK("bus_mode", 2'h1, bus_mode)
    upper <= 3'h5;
    set_mode(2'h0, 2'h0);
    `CHK("bus_mode", 2'h1, bus_mode)
    `CHK("upper_addr", 3'h5, a_out[18:16])
    access(1'b0, 24'h000100, 8'h00, 1'b1, 1'b0, 4'he);
    access(1'b0, 24'h00f800, 8'h00, 1'b0, 1'b0, 4'hf);
    for (int i = 0; i < 4; i++) begin
      set_mode(2'h1, i[1:0]);
      `CHK("ce_size", i[1:0], ce_size)
      access(1'b0, 24'h006000, 8'h00, 1'b1, 1'b0, ce_tab[i]);
    end
    set_mode(2'h2, 2'h0);
    access(1'b0, 24'h000100, 8'h00, 1'b1, 1'b0, 4'he);
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
